// >>> hw/sdw_pkg.sv
// sdw_pkg: shared constants and carrier types for the smbus dac write slave
// assumes nothing beyond a systemverilog compiler
package sdw_pkg;
	localparam int         DAC_W       = 10;
	localparam logic [4:0] ADDR_FIXED  = 5'h0b;   // upper address bits 01011
	localparam logic [9:0] CODE_MID    = 10'h200; // midscale power-up code
	localparam logic [9:0] CODE_ZERO   = 10'h000;
	localparam int         SHUTDOWN_N_POS    = 7;       // shutdown bit in command
	localparam logic [3:0] BIT_LAST    = 4'h7;    // eighth bit of a byte
	localparam logic [3:0] BIT_ACK     = 4'h8;    // ninth clock is acknowledge

	// protocol phase of the slave
	typedef enum logic [2:0] {
		SDW_IDLE = 3'b000,
		SDW_ADDR = 3'b001,
		SDW_CMD  = 3'b010,
		SDW_DATA = 3'b011,
		SDW_DONE = 3'b100
	} sdw_state_t;

	// line events found by the edge finder
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} sdw_bus_ev_t;

	// latched command byte fields
	typedef struct packed {
		logic       shutdown_bit;
		logic [1:0] code_hi;
	} sdw_cmd_t;
endpackage

// >>> hw/sdw_line_sync.sv
// sdw_line_sync: synchronises scl and sda and finds edges and bus conditions
// assumes scl and sda come from outside the clk domain
`timescale 1ns/100ps
module sdw_line_sync
	import sdw_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         clk_en,
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	output sdw_pkg::sdw_bus_ev_t ev
);
	logic [1:0] scl_meta_reg;
	logic [1:0] sda_meta_reg;
	logic       scl_prev_reg;
	logic       sda_prev_reg;

	// two-stage synchronisers; only the second stage is looked at
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_meta_reg <= 2'h3;
			sda_meta_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else if (clk_en) begin
			scl_meta_reg <= {scl_meta_reg[0], scl_in};
			sda_meta_reg <= {sda_meta_reg[0], sda_in};
			scl_prev_reg <= scl_meta_reg[1];
			sda_prev_reg <= sda_meta_reg[1];
		end
	end

	// start and stop need scl high in both samples around the sda edge
	always_comb begin
		ev.scl_rise = clk_en & scl_meta_reg[1] & ~scl_prev_reg;
		ev.scl_fall = clk_en & ~scl_meta_reg[1] & scl_prev_reg;
		ev.start    = clk_en & scl_meta_reg[1] & scl_prev_reg
			& sda_prev_reg & ~sda_meta_reg[1];
		ev.stop     = clk_en & scl_meta_reg[1] & scl_prev_reg
			& ~sda_prev_reg & sda_meta_reg[1];
		ev.sda      = sda_meta_reg[1];
	end
endmodule

// >>> hw/sdw_addr_strap.sv
// sdw_addr_strap: catches the address straps once after reset release
// assumes the straps are static board ties, synchronised here anyway
`timescale 1ns/100ps
module sdw_addr_strap
	import sdw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	input  wire logic       addr_sel_hi,
	input  wire logic       addr_sel_lo,
	output logic [6:0]      slave_addr,
	output logic            straps_valid,
	output logic            midscale
);
	logic [1:0] hi_meta_reg;
	logic [1:0] lo_meta_reg;
	logic [1:0] cnt_reg;

	// straps pass two flops; latched once the pipe holds real pin values
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_meta_reg  <= 2'h0;
			lo_meta_reg  <= 2'h0;
			cnt_reg      <= 2'h0;
			slave_addr   <= 7'h00;
			straps_valid <= 1'b0;
			midscale     <= 1'b0;
		end else if (clk_en) begin
			hi_meta_reg <= {hi_meta_reg[0], addr_sel_hi};
			lo_meta_reg <= {lo_meta_reg[0], addr_sel_lo};
			if (cnt_reg != 2'h3) begin
				cnt_reg <= cnt_reg + 2'h1;
			end else if (!straps_valid) begin
				straps_valid <= 1'b1;
				// low bits: hi,lo 00->01 01->11 10->10 11->00
				slave_addr <= {ADDR_FIXED, hi_meta_reg[1] ^ lo_meta_reg[1],
					~hi_meta_reg[1]};
				midscale   <= hi_meta_reg[1] & lo_meta_reg[1];
			end
		end
	end
endmodule

// >>> hw/sdw_dac_slave.sv
// sdw_dac_slave: receive-only smbus write byte slave loading a 10-bit code
// assumes an open-drain bus resolved outside; scl is sampled, not a clock
`timescale 1ns/100ps
module sdw_dac_slave
	import sdw_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe_n,
	input  wire logic             shutdown_n,
	input  wire logic             addr_sel_hi,
	input  wire logic             addr_sel_lo,
	output logic [sdw_pkg::DAC_W-1:0] dac_code,
	output logic                  output_enable,
	output logic                  shutdown_active
);
	import sdw_pkg::*;

	sdw_bus_ev_t ev;
	logic [6:0]  slave_addr;
	logic        straps_valid;
	logic        midscale;
	sdw_state_t  state_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic        ack_reg;
	sdw_cmd_t    cmd_reg;
	logic [1:0]  shutdown_n_meta_reg;
	logic        code_init_reg;
	logic        shutdown_next;
	logic        ack_due;
	logic        ack_end;

	// count after the ninth rise; the ack clock is the only one not shifted
	localparam logic [3:0] ACK_END = BIT_ACK + 4'h1;

	sdw_line_sync u_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.ev      (ev)
	);

	sdw_addr_strap u_strap (
		.clk          (clk),
		.reset_n      (reset_n),
		.clk_en       (clk_en),
		.addr_sel_hi  (addr_sel_hi),
		.addr_sel_lo  (addr_sel_lo),
		.slave_addr   (slave_addr),
		.straps_valid (straps_valid),
		.midscale     (midscale)
	);

	// the two falls that matter: end of bit eight and end of the ack clock
	// the fall right after a start finds the count at zero and is ignored
	assign ack_due = ev.scl_fall && bit_cnt_reg == BIT_ACK;
	assign ack_end = ev.scl_fall && bit_cnt_reg == ACK_END;

	// byte shifter: sampled on scl rising edges, msb first
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_reg <= 8'h00;
		end else if (ev.scl_rise && state_reg != SDW_IDLE
			&& bit_cnt_reg < BIT_ACK) begin
			shift_reg <= {shift_reg[6:0], ev.sda};
		end
	end

	// rise counter: 1..8 data bits taken, 9 is the acknowledge clock high
	// counting on rises only keeps the fall after start from being a bit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt_reg <= 4'h0;
		end else if (ev.start || ev.stop) begin
			bit_cnt_reg <= 4'h0;
		end else if (state_reg != SDW_IDLE) begin
			if (ev.scl_rise && bit_cnt_reg != ACK_END) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end else if (ack_end) begin
				bit_cnt_reg <= 4'h0;
			end
		end
	end

	// acknowledge decision taken on the fall that ends bit eight
	function automatic logic want_ack(input sdw_state_t st,
		input logic [7:0] byte_in, input logic [6:0] addr);
		case (st)
			SDW_ADDR: want_ack = (byte_in[7:1] == addr)
				&& !byte_in[0];
			SDW_CMD:  want_ack = 1'b1;
			SDW_DATA: want_ack = 1'b1;
			default:  want_ack = 1'b0;
		endcase
	endfunction

	// protocol state; start restarts, stop abandons, mismatch idles
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= SDW_IDLE;
			ack_reg   <= 1'b0;
		end else if (ev.start) begin
			state_reg <= SDW_ADDR;
			ack_reg   <= 1'b0;
		end else if (ev.stop) begin
			state_reg <= SDW_IDLE;
			ack_reg   <= 1'b0;
		end else if (ack_end) begin
			ack_reg <= 1'b0;
			case (state_reg)
				SDW_ADDR: state_reg <= ack_reg ? SDW_CMD : SDW_IDLE;
				SDW_CMD:  state_reg <= SDW_DATA;
				SDW_DATA: state_reg <= SDW_DONE;
				default:  state_reg <= SDW_IDLE;
			endcase
		end else if (ack_due && state_reg != SDW_IDLE
			&& state_reg != SDW_DONE) begin
			// bytes after the data ack are ignored, never acknowledged
			ack_reg <= want_ack(state_reg, shift_reg, slave_addr)
				&& straps_valid;
		end
	end

	// open drain: only ever pull low, during our acknowledge slot
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sda_out  <= 1'b1;
			sda_oe_n <= 1'b1;
		end else if (clk_en) begin
			sda_out  <= 1'b0;
			sda_oe_n <= ~(ack_reg && !ev.start && !ev.stop);
		end
	end

	// command latch at the falling edge ending the command acknowledge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_reg <= '0;
		end else if (ack_end && state_reg == SDW_CMD
			&& !ev.start && !ev.stop) begin
			cmd_reg.shutdown_bit <= shift_reg[SHUTDOWN_N_POS];
			cmd_reg.code_hi      <= shift_reg[1:0];
		end
	end

	// dac code: strap-driven power-up value, then final acknowledge load
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dac_code      <= CODE_ZERO;
			code_init_reg <= 1'b0;
		end else if (clk_en && !code_init_reg && straps_valid) begin
			dac_code      <= midscale ? CODE_MID : CODE_ZERO;
			code_init_reg <= 1'b1;
		end else if (ack_end && state_reg == SDW_DATA
			&& !ev.start && !ev.stop) begin
			dac_code <= {cmd_reg.code_hi, shift_reg};
		end
	end

	// shutdown pin is asynchronous to clk: two flops before use
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shutdown_n_meta_reg <= 2'h0;
		end else if (clk_en) begin
			shutdown_n_meta_reg <= {shutdown_n_meta_reg[0], shutdown_n};
		end
	end

	// either source alone shuts down; dac_code is never touched here
	assign shutdown_next = ~shutdown_n_meta_reg[1]
		| cmd_reg.shutdown_bit;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shutdown_active <= 1'b1;
			output_enable   <= 1'b0;
		end else if (clk_en) begin
			shutdown_active <= shutdown_next;
			output_enable   <= ~shutdown_next & code_init_reg;
		end
	end

	a_ack_only_low: assert property (@(posedge clk) disable iff (!reset_n)
		!sda_oe_n |-> !sda_out) else $error("sda driven high");
	a_ack_slot_only: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(sda_oe_n) |-> $past(ack_reg))
		else $error("sda pulled outside ack");
	a_code_on_ack: assert property (@(posedge clk) disable iff (!reset_n)
		$past(code_init_reg) && $changed(dac_code) |->
		$past(state_reg) == SDW_DATA && $past(bit_cnt_reg) == ACK_END)
		else $error("code changed outside final ack");
	a_stop_idles: assert property (@(posedge clk) disable iff (!reset_n)
		ev.stop && !ev.start |=> state_reg == SDW_IDLE)
		else $error("stop did not abandon");
	a_start_addr: assert property (@(posedge clk) disable iff (!reset_n)
		ev.start |=> state_reg == SDW_ADDR && bit_cnt_reg == 4'h0)
		else $error("start did not restart");
	a_shutdown_n_pin: assert property (@(posedge clk) disable iff (!reset_n)
		!shutdown_n_meta_reg[1] |=> shutdown_active && !output_enable)
		else $error("pin shutdown ignored");
	a_shutdown_bit: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_reg.shutdown_bit |=> shutdown_active)
		else $error("command shutdown ignored");
	a_shutdown_n_keeps: assert property (@(posedge clk) disable iff (!reset_n)
		code_init_reg && shutdown_active && state_reg == SDW_IDLE
		|=> $stable(dac_code)) else $error("code lost");
	a_mismatch_idle: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == SDW_IDLE && !ev.start |=> sda_oe_n)
		else $error("ack while idle");

	// address and sampling: the fixed prefix and rise-only shifting
	a_addr_fixed: assert property (@(posedge clk) disable iff (!reset_n)
		straps_valid |-> slave_addr[6:2] == ADDR_FIXED)
		else $error("fixed address bits wrong");
	a_shift_rise: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(shift_reg) |-> $past(ev.scl_rise))
		else $error("shift outside scl rise");
	a_read_refused: assert property (@(posedge clk) disable iff (!reset_n)
		state_reg == SDW_ADDR && ack_due && shift_reg[0] |=> !ack_reg)
		else $error("read address acknowledged");
	a_ack_clears: assert property (@(posedge clk) disable iff (!reset_n)
		ack_end || ev.stop |=> !ack_reg)
		else $error("ack held past its clock");

	// command and data latches move only on their acknowledge fall
	a_cmd_on_ack: assert property (@(posedge clk) disable iff (!reset_n)
		$changed(cmd_reg) |-> $past(state_reg) == SDW_CMD
		&& $past(bit_cnt_reg) == ACK_END)
		else $error("command latched outside ack");
	a_cmd_fields: assert property (@(posedge clk) disable iff (!reset_n)
		ack_end && state_reg == SDW_CMD |=> cmd_reg.shutdown_bit
		== $past(shift_reg[SHUTDOWN_N_POS]))
		else $error("shutdown bit misplaced");
	a_data_load: assert property (@(posedge clk) disable iff (!reset_n)
		code_init_reg && ack_end && state_reg == SDW_DATA
		|=> dac_code == {cmd_reg.code_hi, $past(shift_reg)})
		else $error("code not loaded at final ack");

	// shutdown from either source, and recovery without a new write
	a_bit_disables: assert property (@(posedge clk) disable iff (!reset_n)
		cmd_reg.shutdown_bit |=> !output_enable)
		else $error("command shutdown left output on");
	a_pin_release: assert property (@(posedge clk) disable iff (!reset_n)
		shutdown_n_meta_reg[1] && !cmd_reg.shutdown_bit && code_init_reg
		|=> output_enable)
		else $error("output not restored");
	a_enable_excl: assert property (@(posedge clk) disable iff (!reset_n)
		output_enable |-> !shutdown_active)
		else $error("enabled while shut down");

	c_write_done: cover property (@(posedge clk) disable iff (!reset_n)
		state_reg == SDW_DATA ##1 state_reg == SDW_DONE);
	c_addr_miss: cover property (@(posedge clk) disable iff (!reset_n)
		state_reg == SDW_ADDR ##1 state_reg == SDW_IDLE);
	c_early_stop: cover property (@(posedge clk) disable iff (!reset_n)
		state_reg == SDW_CMD && ev.stop);
	c_shutdown: cover property (@(posedge clk) disable iff (!reset_n)
		$rose(shutdown_active));
	c_restart: cover property (@(posedge clk) disable iff (!reset_n)
		state_reg == SDW_CMD && ev.start);
endmodule

// >>> testbench/sdw_host.sv
// sdw_host: behavioural smbus host issuing write byte traffic
// assumes the bench resolves sda as a wired-and with a pull-up
`timescale 1ns/100ps
module sdw_host (
	input  wire logic sda_w,
	output logic      scl_o,
	output logic      sda_o
);
	localparam realtime Q = 31.25;
	localparam realtime H = 62.5;

	// both lines released while the bus is idle
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// data only moves while scl is low, so no false start or stop
	task automatic bit_out(input logic b);
		sda_o = b;
		#Q scl_o = 1'b1;
		#H scl_o = 1'b0;
		#Q;
	endtask

	// start, also usable as a repeated start from scl low
	task automatic start();
		sda_o = 1'b1;
		#Q scl_o = 1'b1;
		#H sda_o = 1'b0;
		#H scl_o = 1'b0;
		#Q;
	endtask

	// eight bits msb first, then release sda and read the acknowledge
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		sda_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q ack = !sda_w;
		#Q scl_o = 1'b0;
		#Q;
	endtask

	// stop leaves both lines released
	task automatic stop();
		sda_o = 1'b0;
		#Q scl_o = 1'b1;
		#H sda_o = 1'b1;
		#H;
	endtask
endmodule

// >>> testbench/tb.sv
// tb: self-checking bench for the smbus dac write slave
// assumes sdw_host as the bus master and a pull-up on sda
`timescale 1ns/100ps
module tb;
	import sdw_pkg::*;
	logic             clk, reset_n, shutdown_n, addr_sel_hi, addr_sel_lo;
	logic             scl_o, sda_o, sda_out, sda_oe_n, ack;
	logic             output_enable, shutdown_active;
	logic [DAC_W-1:0] dac_code, cur, code;
	logic [6:0]       addr;
	logic [1:0]       low_tab [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
	logic [9:0]       exp_q [$];
	int               failures, compares, seed;
	// wired-and with pull-up; device pulls low only when enabled
	wire              sda_w = sda_o & (sda_oe_n | sda_out);

	sdw_dac_slave dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
		.scl_in(scl_o), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .shutdown_n(shutdown_n),
		.addr_sel_hi(addr_sel_hi), .addr_sel_lo(addr_sel_lo),
		.dac_code(dac_code), .output_enable(output_enable),
		.shutdown_active(shutdown_active));
	sdw_host host (.sda_w(sda_w), .scl_o(scl_o), .sda_o(sda_o));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [9:0] e, g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic snd(input logic [7:0] b, input logic e);
		host.send_byte(b, ack);
		chk("ack", {9'h0, e}, {9'h0, ack});
	endtask

	// write byte; ignored command bits are all ones to prove they stay out
	task automatic wr(input logic [6:0] a, input logic sd, input logic ok);
		host.start();
		snd({a, 1'b0}, ok);
		if (ok) begin
			snd({sd, 5'h1f, code[9:8]}, 1'b1);
			if (code != cur) begin
				exp_q.push_back(code);
				cur = code;
			end
			snd(code[7:0], 1'b1);
		end
	endtask

	task automatic settle();
		repeat (8) @(negedge clk);
	endtask

	// result watcher: every code change out of reset must match the oldest note, or cur when no note is queued
	initial forever begin
		@(dac_code);
		if (reset_n === 1'b1) begin
			if (exp_q.size() == 0)
				chk("dac_code", cur, dac_code);
			else
				chk("dac_code", exp_q.pop_front(), dac_code);
		end
	end

	// watchdog well beyond the expected run of about 95 us
	initial begin
		#600000;
		failures++;
		summarize();
	end

	initial begin
		seed = 48134;
		reset_n = 1'b0;
		shutdown_n = 1'b1;
		{addr_sel_hi, addr_sel_lo} = 2'h0;
		for (int s = 0; s < 4; s++) begin
			@(negedge clk);
			reset_n = 1'b0;
			{addr_sel_hi, addr_sel_lo} = s[1:0];
			repeat (10) @(negedge clk);
			cur = (s == 3) ? CODE_MID : CODE_ZERO;
			if (s == 3)
				exp_q.push_back(CODE_MID);
			reset_n = 1'b1;
			repeat (20) @(negedge clk);
			chk("power-up code", cur, dac_code);
			addr = {ADDR_FIXED, low_tab[s]};
			wr(addr ^ 7'h01, 1'b0, 1'b0);
			wr(addr ^ 7'h42, 1'b0, 1'b0);
			code = 10'($random(seed));
			wr(addr, 1'b0, 1'b1);
			// stop inside the data byte: code must not move
			host.start();
			snd({addr, 1'b0}, 1'b1);
			snd(8'h02, 1'b1);
			host.bit_out(1'b1);
			host.stop();
			// repeated start inside the command byte, then a full write
			host.start();
			snd({addr, 1'b0}, 1'b1);
			host.bit_out(1'b0);
			code = cur ^ 10'h2a5;
			wr(addr, 1'b0, 1'b1);
			host.stop();
			settle();
			chk("enable", 10'h1, {9'h0, output_enable});
			@(negedge clk);
			shutdown_n = 1'b0;
			settle();
			chk("pin shutdown", 10'h1, {9'h0, shutdown_active});
			chk("pin enable", 10'h0, {9'h0, output_enable});
			@(negedge clk);
			shutdown_n = 1'b1;
			settle();
			chk("release", 10'h1, {9'h0, output_enable});
			chk("kept code", cur, dac_code);
			code = cur ^ 10'h0f0;
			wr(addr, 1'b1, 1'b1);
			host.stop();
			settle();
			chk("cmd shutdown", 10'h1, {9'h0, shutdown_active});
			chk("cmd enable", 10'h0, {9'h0, output_enable});
			code = cur ^ 10'h301;
			wr(addr, 1'b0, 1'b1);
			host.stop();
			settle();
			chk("cmd resume", 10'h0, {9'h0, shutdown_active});
			// read transfers are refused
			host.start();
			snd({addr, 1'b1}, 1'b0);
			host.stop();
			settle();
			chk("notes left", 10'h0, 10'(exp_q.size()));
			$display("test straps %0d done", s);
		end
		summarize();
	end
endmodule
